// file: inc/dma_pkg.sv
// Shared constants and types of the multichannel DMA core.
package dma_pkg;
  localparam int NUM_CH = 32;
  localparam int CH_W = 5;
  localparam int APB_AW = 8;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] ENA_SET_OFS = 8'h00;
  localparam logic [7:0] ENA_CLR_OFS = 8'h04;
  localparam logic [7:0] PRIO_SET_OFS = 8'h08;
  localparam logic [7:0] PRIO_CLR_OFS = 8'h0c;
  localparam logic [7:0] TBL_BASE_OFS = 8'h10;
  localparam logic [7:0] SW_REQ_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] ALT_STAT_OFS = 8'h1c;
  // Control table geometry.
  localparam int BASE_LSB = 10;
  localparam int BASE_W = 32 - BASE_LSB;
  localparam logic [3:0] SRC_END_OFS = 4'h0;
  localparam logic [3:0] DST_END_OFS = 4'h4;
  localparam logic [3:0] CTL_OFS = 4'h8;
  // Control word fields.
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int CNT_LSB = 4;
  localparam int CNT_W = 10;
  localparam int ARB_LSB = 14;
  localparam int ARB_W = 4;
  localparam int SRC_INC_LSB = 26;
  localparam int DST_INC_LSB = 30;
  localparam logic [1:0] INC_NONE = 2'h3;
  localparam logic [ARB_W-1:0] ARB_MAX_LOG = 4'ha;
  localparam int BURST_W = 11;
  typedef enum logic [2:0] {
    MODE_STOP = 3'h0,
    MODE_BASIC = 3'h1,
    MODE_AUTO = 3'h2,
    MODE_PINGPONG = 3'h3
  } mode_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH_SRC = 3'h1,
    ST_FETCH_DST = 3'h3,
    ST_FETCH_CTL = 3'h2,
    ST_READ = 3'h6,
    ST_WRITE = 3'h7,
    ST_WBACK = 3'h5
  } state_type;
endpackage : dma_pkg

// file: design/prio_pick.sv
// Fixed-priority picker: the lowest set index wins.
`timescale 1ns/1ps
`default_nettype none
module prio_pick #(
  parameter int N = 32,
  parameter int IW = 5
) (
  input wire logic [N-1:0] vec_in,
  output logic any_out,
  output logic [IW-1:0] idx_out
);
  always_comb
  begin
    any_out = |vec_in;
    idx_out = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (vec_in[i])
      begin
        idx_out = IW'(i);
      end
    end
  end
endmodule : prio_pick
`default_nettype wire

// file: design/sys_bus_port.sv
// Single-access master port on the system bus shared with the processor.
`timescale 1ns/1ps
`default_nettype none
module sys_bus_port #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_we_in,
  input wire logic [AW-1:0] cmd_addr_in,
  input wire logic [DW-1:0] cmd_wdata_in,
  input wire logic cpu_busy_in,
  input wire logic mem_ready_in,
  input wire logic [DW-1:0] mem_rdata_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [AW-1:0] mem_addr_out,
  output logic [DW-1:0] mem_wdata_out,
  output logic done_out,
  output logic [DW-1:0] rdata_out
);
  logic issue;

  // A new access starts only while the processor leaves the bus alone.
  assign issue = cmd_valid_in && !mem_req_out && !done_out && !cpu_busy_in;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= '0;
      mem_wdata_out <= '0;
    end
    else if (issue)
    begin
      mem_req_out <= 1'b1;
      mem_we_out <= cmd_we_in;
      mem_addr_out <= cmd_addr_in;
      mem_wdata_out <= cmd_wdata_in;
    end
    else if (mem_req_out && mem_ready_in)
    begin
      mem_req_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      done_out <= 1'b0;
      rdata_out <= '0;
    end
    else
    begin
      done_out <= mem_req_out && mem_ready_in;
      if (mem_req_out && mem_ready_in && !mem_we_out)
      begin
        rdata_out <= mem_rdata_in;
      end
    end
  end
endmodule : sys_bus_port
`default_nettype wire

// file: design/dma_core.sv
// Multichannel DMA core with APB registers and a shared system bus port.
//
// How it works
// - Same level: lower channel number wins, channel 0 highest.
// - High-priority channels outrank all default-priority channels.
// - Among high-priority channels the lowest number wins.
// - Priority set/clear registers set and clear each channel's level bit.
// - Arbitration looks only at requesting channels and grants the best.
// - A grant moves up to the burst item count, 1 to 1024, then re-arbitrates.
// - The processor wins the bus before each access starts; an issued access is held to completion; accesses stall, even mid-burst.
// - Entry at base plus 0x10 per channel; alternate adds 0x200.
// - Entry words: source end, destination end, control, unused.
// - End pointers are inclusive; a fixed side uses the pointer itself.
// - On completion control word shows count 0 and mode stop.
// - The core clears a channel's enable when its transfer finishes, except in ping-pong mode.
// - Stop mode moves nothing and disables the channel.
// - Basic mode moves items only while the request stays asserted.
// - Basic mode ends by setting the mode field to stop.
// - Auto mode runs to completion after one request, then stop.
// - Ping-pong starts primary, swaps entry and signals each completion.
// - Thirty-two channels, each with its own request and entries.
// - Each channel has its own completion pulse output.
`timescale 1ns/1ps
`default_nettype none
module dma_core (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [dma_pkg::APB_AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [dma_pkg::NUM_CH-1:0] req_in,
  input wire logic cpu_busy_in,
  input wire logic mem_ready_in,
  input wire logic [31:0] mem_rdata_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  output logic [dma_pkg::NUM_CH-1:0] done_out
);
  import dma_pkg::*;

  logic [NUM_CH-1:0] ena_r;
  logic [NUM_CH-1:0] prio_r;
  logic [NUM_CH-1:0] sw_pend_r;
  logic [NUM_CH-1:0] hold_r;
  logic [NUM_CH-1:0] alt_r;
  logic [BASE_W-1:0] base_r;
  state_type state_r;
  logic [CH_W-1:0] ch_r;
  logic [31:0] src_end_r;
  logic [31:0] dst_end_r;
  logic [31:0] ctl_r;
  logic [31:0] data_r;
  mode_type mode_r;
  logic cmpl_r;
  logic [BURST_W-1:0] burst_r;

  logic apb_acc;
  logic apb_wr;
  logic mapped;
  logic [31:0] rd_mux;
  logic [NUM_CH-1:0] wr_ena_set;
  logic [NUM_CH-1:0] wr_ena_clr;
  logic [NUM_CH-1:0] wr_prio_set;
  logic [NUM_CH-1:0] wr_prio_clr;
  logic [NUM_CH-1:0] wr_sw_req;
  logic [NUM_CH-1:0] elig;
  logic [NUM_CH-1:0] ch_bit;
  logic hi_any;
  logic all_any;
  logic [CH_W-1:0] hi_idx;
  logic [CH_W-1:0] all_idx;
  logic [CH_W-1:0] pick;
  logic grant;
  logic bus_valid;
  logic bus_we;
  logic [31:0] bus_addr;
  logic bus_done;
  logic [31:0] bus_rdata;
  logic [31:0] entry_addr;
  mode_type fetched_mode;
  logic [CNT_W-1:0] cnt;
  logic [ARB_W-1:0] arb_log;
  logic still_req;
  logic fetch_ctl_done;
  logic stop_seen;
  logic finish;
  logic [NUM_CH-1:0] hw_dis;

  // APB: one wait state, so every access ends on its second access cycle.
  assign apb_acc = psel_in && penable_in && pready_out;
  assign apb_wr = apb_acc && pwrite_in && mapped;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (paddr_in)
      ENA_SET_OFS, ENA_CLR_OFS: rd_mux = ena_r;
      PRIO_SET_OFS, PRIO_CLR_OFS: rd_mux = prio_r;
      TBL_BASE_OFS: rd_mux = {base_r, 10'h0};
      SW_REQ_OFS: rd_mux = sw_pend_r;
      STATUS_OFS: rd_mux = {23'h0, ch_r, 3'h0, state_r != ST_IDLE};
      ALT_STAT_OFS: rd_mux = alt_r;
      default: mapped = 1'b0;
    endcase
  end

  assign wr_ena_set = (apb_wr && paddr_in == ENA_SET_OFS) ? pwdata_in : '0;
  assign wr_ena_clr = (apb_wr && paddr_in == ENA_CLR_OFS) ? pwdata_in : '0;
  assign wr_prio_set = (apb_wr && paddr_in == PRIO_SET_OFS) ? pwdata_in : '0;
  assign wr_prio_clr = (apb_wr && paddr_in == PRIO_CLR_OFS) ? pwdata_in : '0;
  assign wr_sw_req = (apb_wr && paddr_in == SW_REQ_OFS) ? pwdata_in : '0;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= psel_in && penable_in && !pready_out;
      if (psel_in && penable_in && !pready_out)
      begin
        prdata_out <= pwrite_in ? 32'h0 : rd_mux;
        pslverr_out <= !mapped;
      end
      else
      begin
        pslverr_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prio_r <= '0;
      base_r <= '0;
    end
    else
    begin
      prio_r <= (prio_r & ~wr_prio_clr) | wr_prio_set;
      if (apb_wr && paddr_in == TBL_BASE_OFS)
      begin
        base_r <= pwdata_in[31:BASE_LSB];
      end
    end
  end

  // Software set wins over a same-cycle clear from either side.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ena_r <= '0;
      alt_r <= '0;
    end
    else
    begin
      ena_r <= (ena_r & ~wr_ena_clr & ~hw_dis) | wr_ena_set;
      if (finish && mode_r == MODE_PINGPONG)
      begin
        alt_r <= (alt_r ^ ch_bit) & ~wr_ena_set;
      end
      else
      begin
        alt_r <= alt_r & ~wr_ena_set;
      end
    end
  end

  // A software request lasts one burst; only a new write in the cycle that ends it is kept.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sw_pend_r <= '0;
      hold_r <= '0;
    end
    else
    begin
      if ((state_r == ST_WBACK && bus_done) || (fetch_ctl_done && stop_seen))
      begin
        sw_pend_r <= (sw_pend_r & ~ch_bit) | wr_sw_req;
      end
      else
      begin
        sw_pend_r <= sw_pend_r | wr_sw_req;
      end
      if (fetch_ctl_done && fetched_mode == MODE_AUTO)
      begin
        hold_r <= hold_r | ch_bit;
      end
      else if (finish || (fetch_ctl_done && stop_seen))
      begin
        hold_r <= hold_r & ~ch_bit;
      end
    end
  end

  assign elig = ena_r & (req_in | sw_pend_r | hold_r);

  prio_pick #(
    .N(NUM_CH),
    .IW(CH_W)
  ) u_pick_high (
    .vec_in(elig & prio_r),
    .any_out(hi_any),
    .idx_out(hi_idx)
  );

  prio_pick #(
    .N(NUM_CH),
    .IW(CH_W)
  ) u_pick_all (
    .vec_in(elig),
    .any_out(all_any),
    .idx_out(all_idx)
  );

  assign pick = hi_any ? hi_idx : all_idx;
  assign grant = state_r == ST_IDLE && all_any;
  assign ch_bit = NUM_CH'(1) << ch_r;

  assign entry_addr = {base_r, alt_r[ch_r], ch_r, 4'h0};
  assign fetched_mode = mode_type'(bus_rdata[MODE_LSB +: MODE_W]);
  assign cnt = ctl_r[CNT_LSB +: CNT_W];
  assign arb_log = (bus_rdata[ARB_LSB +: ARB_W] > ARB_MAX_LOG) ?
                   ARB_MAX_LOG : bus_rdata[ARB_LSB +: ARB_W];
  assign still_req = req_in[ch_r] || sw_pend_r[ch_r] ||
                     mode_r != MODE_BASIC;
  assign fetch_ctl_done = state_r == ST_FETCH_CTL && bus_done;
  assign stop_seen = fetched_mode != MODE_BASIC &&
                     fetched_mode != MODE_AUTO &&
                     fetched_mode != MODE_PINGPONG;
  assign finish = state_r == ST_WBACK && bus_done && cmpl_r;

  always_comb
  begin
    hw_dis = '0;
    if (fetch_ctl_done && stop_seen)
    begin
      hw_dis = ch_bit;
    end
    else if (finish && mode_r != MODE_PINGPONG)
    begin
      hw_dis = ch_bit;
    end
  end

  // Item address counts back from the inclusive end pointer.
  function automatic logic [31:0] item_addr(input logic [31:0] end_ptr,
                                            input logic [1:0] inc,
                                            input logic [CNT_W-1:0] left);
    if (inc == INC_NONE)
    begin
      item_addr = end_ptr;
    end
    else
    begin
      item_addr = end_ptr - ({22'h0, left} << inc);
    end
  endfunction : item_addr

  always_comb
  begin
    bus_valid = 1'b1;
    bus_we = 1'b0;
    bus_addr = entry_addr;
    case (state_r)
      ST_FETCH_SRC: bus_addr = entry_addr | {28'h0, SRC_END_OFS};
      ST_FETCH_DST: bus_addr = entry_addr | {28'h0, DST_END_OFS};
      ST_FETCH_CTL: bus_addr = entry_addr | {28'h0, CTL_OFS};
      ST_READ: bus_addr = item_addr(src_end_r,
                                    ctl_r[SRC_INC_LSB +: 2], cnt);
      ST_WRITE:
      begin
        bus_we = 1'b1;
        bus_addr = item_addr(dst_end_r, ctl_r[DST_INC_LSB +: 2], cnt);
      end
      ST_WBACK:
      begin
        bus_we = 1'b1;
        bus_addr = entry_addr | {28'h0, CTL_OFS};
      end
      default: bus_valid = 1'b0;
    endcase
  end

  sys_bus_port #(
    .AW(32),
    .DW(32)
  ) u_port (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .cmd_valid_in(bus_valid),
    .cmd_we_in(bus_we),
    .cmd_addr_in(bus_addr),
    .cmd_wdata_in(state_r == ST_WBACK ? ctl_r : data_r),
    .cpu_busy_in(cpu_busy_in),
    .mem_ready_in(mem_ready_in),
    .mem_rdata_in(mem_rdata_in),
    .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out),
    .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out),
    .done_out(bus_done),
    .rdata_out(bus_rdata)
  );

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      ch_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (grant)
          begin
            ch_r <= pick;
            state_r <= ST_FETCH_SRC;
          end
        end
        ST_FETCH_SRC:
        begin
          if (bus_done)
          begin
            state_r <= ST_FETCH_DST;
          end
        end
        ST_FETCH_DST:
        begin
          if (bus_done)
          begin
            state_r <= ST_FETCH_CTL;
          end
        end
        ST_FETCH_CTL:
        begin
          if (bus_done)
          begin
            state_r <= stop_seen ? ST_IDLE : ST_READ;
          end
        end
        ST_READ:
        begin
          if (bus_done)
          begin
            state_r <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (bus_done)
          begin
            if (cnt == '0 || burst_r == BURST_W'(1) || !still_req)
            begin
              state_r <= ST_WBACK;
            end
            else
            begin
              state_r <= ST_READ;
            end
          end
        end
        ST_WBACK:
        begin
          if (bus_done)
          begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      src_end_r <= '0;
      dst_end_r <= '0;
      data_r <= '0;
    end
    else if (bus_done)
    begin
      if (state_r == ST_FETCH_SRC)
      begin
        src_end_r <= bus_rdata;
      end
      if (state_r == ST_FETCH_DST)
      begin
        dst_end_r <= bus_rdata;
      end
      if (state_r == ST_READ)
      begin
        data_r <= bus_rdata;
      end
    end
  end

  // Working copy of the control word; only this copy is written back.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctl_r <= '0;
      mode_r <= MODE_STOP;
      cmpl_r <= 1'b0;
      burst_r <= '0;
    end
    else if (fetch_ctl_done)
    begin
      ctl_r <= bus_rdata;
      mode_r <= fetched_mode;
      cmpl_r <= 1'b0;
      burst_r <= BURST_W'(1) << arb_log;
    end
    else if (state_r == ST_WRITE && bus_done)
    begin
      burst_r <= burst_r - BURST_W'(1);
      if (cnt == '0)
      begin
        cmpl_r <= 1'b1;
        ctl_r[MODE_LSB +: MODE_W] <= MODE_STOP;
      end
      else
      begin
        ctl_r[CNT_LSB +: CNT_W] <= cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      done_out <= '0;
    end
    else
    begin
      done_out <= finish ? ch_bit : '0;
    end
  end
endmodule : dma_core
`default_nettype wire

// file: dv/dma_core_assertions.sv
// Concurrent checks on the ports of the DMA core.
`timescale 1ns/1ps
`default_nettype none
module dma_core_checker (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [dma_pkg::APB_AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cpu_busy_in,
  input wire logic mem_ready_in,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic [dma_pkg::NUM_CH-1:0] done_out
);
  import dma_pkg::*;
  logic [BASE_W-1:0] base_r;
  logic [31:0] prev_addr_r;
  logic prev_tbl_r;
  logic wb_done;
  assign wb_done = mem_req_out && mem_ready_in && mem_we_out &&
    mem_addr_out[3:0] == CTL_OFS && mem_addr_out[31:BASE_LSB] == base_r;
  // Tracks the table base and the last finished bus access.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      base_r <= '0;
      prev_addr_r <= 32'h0;
      prev_tbl_r <= 1'b0;
    end
    else
    begin
      if (psel_in && penable_in && pready_out && pwrite_in &&
          paddr_in == TBL_BASE_OFS)
        base_r <= pwdata_in[31:BASE_LSB];
      if (mem_req_out && mem_ready_in)
      begin
        prev_addr_r <= mem_addr_out;
        prev_tbl_r <= !mem_we_out && mem_addr_out[31:BASE_LSB] == base_r;
      end
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  AST_CPU_YIELD: assert property (
    $rose(mem_req_out) |-> !$past(cpu_busy_in))
    else $error("bus request issued while processor busy");
  AST_REQ_HOLD: assert property (
    mem_req_out && !mem_ready_in |=> mem_req_out && $stable(mem_addr_out)
      && $stable(mem_we_out) && $stable(mem_wdata_out))
    else $error("bus request changed before completion");
  AST_REQ_DROP: assert property (
    mem_req_out && mem_ready_in |=> !mem_req_out)
    else $error("bus request not released after completion");
  AST_APB_WAIT: assert property (
    psel_in && penable_in && !$past(penable_in) |-> !pready_out ##1 pready_out)
    else $error("register access not answered after one wait state");
  AST_SLVERR: assert property (
    pready_out |-> pslverr_out ==
      !(paddr_in[1:0] == 2'h0 && paddr_in <= ALT_STAT_OFS))
    else $error("error response does not match address map");
  AST_DONE_PULSE: assert property (
    done_out != '0 |-> $onehot0(done_out) ##1 (done_out & $past(done_out)) == '0)
    else $error("completion pulse wrong");
  AST_DONE_AFTER_WB: assert property (
    done_out != '0 |-> $past(wb_done) || $past(wb_done, 2) || $past(wb_done, 3))
    else $error("completion without control word writeback");
  AST_ENTRY_ORDER: assert property (
    $rose(mem_req_out) && prev_tbl_r && prev_addr_r[3:0] != CTL_OFS |->
      !mem_we_out && mem_addr_out == prev_addr_r + 32'h4)
    else $error("entry words fetched out of order");
endmodule : dma_core_checker
bind dma_core dma_core_checker dma_core_checker_inst (.mclk_in(mclk_in),
  .rst_in(rst_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .cpu_busy_in(cpu_busy_in), .mem_ready_in(mem_ready_in),
  .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
  .done_out(done_out));
`default_nettype wire

// file: dv/sys_mem_model.sv
// System memory model answering the core after programmable wait states.
`timescale 1ns/1ps
`default_nettype none
module sys_mem_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wait_in,
  output logic ready_out,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [0:1023];
  logic [3:0] cnt_r;
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 32'h0;
  end
  // Read data is only valid with ready; otherwise it toggles every cycle.
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ready_out <= 1'b0;
      cnt_r <= 4'h0;
      rdata_out <= 32'h0;
    end
    else if (ready_out)
    begin
      ready_out <= 1'b0;
      cnt_r <= 4'h0;
      rdata_out <= ~rdata_out;
      if (we_in)
        mem[addr_in[11:2]] <= wdata_in;
    end
    else if (req_in && cnt_r >= wait_in)
    begin
      ready_out <= 1'b1;
      rdata_out <= mem[addr_in[11:2]];
    end
    else
    begin
      cnt_r <= req_in ? cnt_r + 4'h1 : 4'h0;
      rdata_out <= ~rdata_out;
    end
  end
endmodule : sys_mem_model
`default_nettype wire

// file: dv/tb_dma_core.sv
// Self-checking testbench for the multichannel DMA core.
`timescale 1ns/1ps
`default_nettype none
module tb_dma_core;
  import dma_pkg::*;
  logic mclk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out;
  logic pslverr_out, cpu_busy_in, mem_ready_in, mem_req_out, mem_we_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, mem_rdata_in, mem_addr_out;
  logic [31:0] mem_wdata_out, req_in, done_out, rd, c4;
  logic [3:0] mem_wait;
  logic [2:0] cyc;
  logic err;
  int num_errors = 0;
  int n_checks = 0;
  int done_q[$];
  int ord[4] = '{9, 12, 2, 5};
  dma_core dma_core_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .req_in(req_in),
    .cpu_busy_in(cpu_busy_in), .mem_ready_in(mem_ready_in),
    .mem_rdata_in(mem_rdata_in), .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .done_out(done_out));
  sys_mem_model sys_mem_model_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .wait_in(mem_wait),
    .ready_out(mem_ready_in), .rdata_out(mem_rdata_in));
  initial
  begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 3'h1;
    cpu_busy_in <= (cyc == 3'h5);
  end
  always @(posedge mclk_in)
    for (int c = 0; c < NUM_CH; c++)
      if (done_out[c] === 1'b1)
        done_q.push_back(c);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk_in);
      i++;
    end
    while (pready_out !== 1'b1 && i < 20);
    rd = prdata_out;
    err = pslverr_out;
    chk("apb ready", 32'h1, {31'h0, pready_out});
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  function automatic logic [31:0] mw(input int i);
    return sys_mem_model_inst.mem[i];
  endfunction : mw
  // Entries sit at channel times 0x10, alternates 0x200 further on.
  task put(input int ch, input int alt, input logic [31:0] s, d, c);
    sys_mem_model_inst.mem[alt * 128 + ch * 4] = s;
    sys_mem_model_inst.mem[alt * 128 + ch * 4 + 1] = d;
    sys_mem_model_inst.mem[alt * 128 + ch * 4 + 2] = c;
  endtask : put
  function automatic logic [31:0] ctlw(input logic [2:0] m, input int n,
    input logic [3:0] arb, input logic [1:0] si, di);
    return {di, 2'b00, si, 8'h00, arb, 10'(n - 1), 1'b0, m};
  endfunction : ctlw
  task wait_done(input int n);
    int i;
    i = 0;
    while (done_q.size() < n && i < 3000)
    begin
      @(posedge mclk_in);
      i++;
    end
    chk("completions", 32'(n), 32'(done_q.size()));
  endtask : wait_done
  task wait_idle;
    for (int i = 0; i < 100; i++)
    begin
      apb(1'b0, SW_REQ_OFS, 32'h0);
      if (rd === 32'h0)
      begin
        apb(1'b0, STATUS_OFS, 32'h0);
        if (rd[0] === 1'b0)
          break;
      end
    end
  endtask : wait_idle
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (30000) @(posedge mclk_in);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end
  initial
  begin
    rst_in = 1'b1;
    {psel_in, penable_in, pwrite_in, cpu_busy_in} = 4'h0;
    {paddr_in, pwdata_in, req_in, cyc, mem_wait} = '0;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    rdchk(ENA_SET_OFS, 32'h0, "enable reset");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, TBL_BASE_OFS, 32'h0);
    $display("test registers done");
    mem_wait <= 4'h2;
    for (int i = 0; i < 4; i++)
      sys_mem_model_inst.mem[256 + i] = 32'h1000 + i;
    c4 = ctlw(MODE_AUTO, 4, 4'h1, 2'h2, 2'h2);
    put(3, 0, 32'h40c, 32'h50c, c4);
    apb(1'b1, ENA_SET_OFS, 32'h8);
    apb(1'b1, SW_REQ_OFS, 32'h8);
    wait_done(1);
    for (int i = 0; i < 4; i++)
      chk("auto dst", 32'h1000 + i, mw(320 + i));
    chk("auto ctl", c4 & 32'hffffc000, mw(14));
    chk("auto src end", 32'h40c, mw(12));
    rdchk(ENA_SET_OFS, 32'h0, "auto enable");
    $display("test auto done");
    done_q.delete();
    mem_wait <= 4'h0;
    sys_mem_model_inst.mem[384] = 32'hcafe0001;
    c4 = ctlw(MODE_BASIC, 4, 4'h1, 2'h3, 2'h2);
    put(4, 0, 32'h600, 32'h70c, c4);
    apb(1'b1, ENA_SET_OFS, 32'h10);
    apb(1'b1, SW_REQ_OFS, 32'h10);
    wait_idle();
    for (int i = 0; i < 4; i++)
      chk("basic burst", i < 2 ? 32'hcafe0001 : 32'h0, mw(448 + i));
    chk("basic ctl", (c4 & 32'hffffc00f) | 32'h10, mw(18));
    apb(1'b1, SW_REQ_OFS, 32'h10);
    wait_done(1);
    chk("basic last", 32'hcafe0001, mw(451));
    chk("basic ctl end", c4 & 32'hffffc000, mw(18));
    rdchk(ENA_SET_OFS, 32'h0, "basic enable");
    $display("test basic done");
    done_q.delete();
    mem_wait <= 4'h1;
    foreach (ord[k])
      put(ord[k], 0, 32'h600, 32'h800, ctlw(MODE_AUTO, 1, 4'h0, 2'h3, 2'h3));
    put(0, 0, 32'h600, 32'h800, ctlw(MODE_AUTO, 1, 4'h0, 2'h3, 2'h3));
    apb(1'b1, ENA_SET_OFS, 32'h1225);
    apb(1'b1, PRIO_SET_OFS, 32'h1200);
    rdchk(PRIO_SET_OFS, 32'h1200, "prio set");
    apb(1'b1, PRIO_CLR_OFS, 32'h1000);
    rdchk(PRIO_CLR_OFS, 32'h0200, "prio clear");
    apb(1'b1, PRIO_SET_OFS, 32'h1000);
    req_in <= 32'h1224;
    wait_done(4);
    req_in <= 32'h0;
    foreach (ord[k])
      chk("grant order", ord[k], done_q[k]);
    rdchk(ENA_SET_OFS, 32'h1, "idle channel kept");
    apb(1'b1, ENA_CLR_OFS, 32'h1);
    rdchk(ENA_CLR_OFS, 32'h0, "enable clear");
    apb(1'b1, PRIO_CLR_OFS, 32'h1200);
    $display("test priority done");
    mem_wait <= 4'h3;
    put(7, 0, 32'h600, 32'ha00, ctlw(MODE_STOP, 1, 4'h0, 2'h3, 2'h3));
    apb(1'b1, ENA_SET_OFS, 32'h80);
    apb(1'b1, SW_REQ_OFS, 32'h80);
    wait_idle();
    chk("stop dst", 32'h0, mw(640));
    rdchk(ENA_SET_OFS, 32'h0, "stop enable");
    $display("test stop done");
    done_q.delete();
    sys_mem_model_inst.mem[385] = 32'h5a5a0002;
    c4 = ctlw(MODE_PINGPONG, 1, 4'h0, 2'h3, 2'h3);
    put(1, 0, 32'h600, 32'h900, c4);
    put(1, 1, 32'h604, 32'h904, c4);
    apb(1'b1, ENA_SET_OFS, 32'h2);
    apb(1'b1, SW_REQ_OFS, 32'h2);
    wait_done(1);
    chk("ping dst", 32'hcafe0001, mw(576));
    rdchk(ALT_STAT_OFS, 32'h2, "alt after ping");
    rdchk(ENA_SET_OFS, 32'h2, "ping enable");
    apb(1'b1, SW_REQ_OFS, 32'h2);
    wait_done(2);
    chk("pong dst", 32'h5a5a0002, mw(577));
    rdchk(ALT_STAT_OFS, 32'h0, "alt after pong");
    apb(1'b1, ENA_CLR_OFS, 32'h2);
    $display("test pingpong done");
    finish_test();
  end
endmodule : tb_dma_core
`default_nettype wire
